// ==== design/spi_serial_port.v ====
// spi serial port: one port that serves as master or slave, with its
// register file on a plain strobe port.
// assumes a single 25 mhz clock; all pin inputs are asynchronous and are
// synchronised here; the bench resolves the two-way pins from the enables.
//
// Function
// - mosi is driven while master, sampled as input while slave.
// - as master mosi carries the shift register msb, msb first.
// - miso is input while master, driven msb first while a selected slave.
// - miso released when port disabled or 4-wire slave not selected.
// - 3-wire slave drives miso from shift register msb at all times.
// - master generates sck; slave takes sck from the external master.
// - 4-wire slave ignores sck while nss is high.
// - select mode 00 is 3-wire, nss unused, slave always selected.
// - select mode 01 takes nss as input selecting the slave.
// - mode 01 master loses master function on nss falling edge.
// - select mode 1x drives nss out at the select level bit.
// - select mode 1x is meant for master operation only.
// - nss is routed to a pin in every mode except 3-wire.
// - only a master starts transfers; slaves wait for the master.
// - master enable bit set selects master, clear selects slave.
// - master data register write goes to the transmit buffer.
// - empty shift register with full transmit buffer loads and starts.
// - a started master transfer shifts out at once with sck running.
// - transfer done flag set at every byte end, cleared by software.
// - data write while transmit buffer full is dropped, collision flagged.
// - mode fault sets its flag and clears master and port enables.
// - slave overrun keeps the old byte, drops new, sets overrun flag.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "spi_serial_port_consts.vh"

module spi_serial_port (
   input  wire                 clock_i,
   input  wire                 rst_n_i,
   input  wire [`ADDR_W-1:0]   addr_i,
   input  wire [`DATA_W-1:0]   wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [`DATA_W-1:0]   rdata_o,
   input  wire                 sck_i,
   output reg                  sck_o,
   output reg                  sck_oe_o,
   input  wire                 mosi_i,
   output reg                  mosi_o,
   output reg                  mosi_oe_o,
   input  wire                 miso_i,
   output reg                  miso_o,
   output reg                  miso_oe_o,
   input  wire                 nss_i,
   output reg                  nss_o,
   output reg                  nss_oe_o,
   output reg                  nss_pin_en_o
);

   // master sequencer states, one-hot
   localparam [2:0] M_IDLE = 3'b001;
   localparam [2:0] M_LOW  = 3'b010;
   localparam [2:0] M_HIGH = 3'b100;

   // ----------------------------------------------------------------------
   // helper
   // ----------------------------------------------------------------------
   // address match, used by both the write and the read decode
   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg  [3:0]          ctl_q;            // select mode, master and port enables
   reg  [`FLAG_W-1:0]  flag_q;           // done, collision, fault, overrun
   reg  [`DATA_W-1:0]  div_q;            // master half period minus one
   reg  [`DATA_W-1:0]  tx_buf_q;
   reg                 tx_full_q;
   reg  [`DATA_W-1:0]  rx_buf_q;
   reg                 rx_full_q;
   reg  [`DATA_W-1:0]  shift_q;
   reg                 sample_q;         // bit caught on the leading edge
   reg  [`BIT_CNT_W-1:0] bit_q;
   reg                 slave_busy_q;
   reg  [2:0]          mstate_q;
   reg  [`DATA_W-1:0]  tick_q;
   reg                 sck_int_q;

   // synchronisers: stage 1 feeds stage 2 only; stage 3 is edge history
   reg  [2:0]          sck_s_q;
   reg  [2:0]          nss_s_q;
   reg  [1:0]          mosi_s_q;
   reg  [1:0]          miso_s_q;

   // ----------------------------------------------------------------------
   // decode of the control bits
   // ----------------------------------------------------------------------
   wire [1:0] sel_mode  = ctl_q[`CTL_SEL_OUT_EN:`CTL_SEL_LEVEL];
   wire       port_en   = ctl_q[`CTL_PORT_EN];
   wire       master    = port_en & ctl_q[`CTL_MASTER_EN];
   wire       slave     = port_en & ~ctl_q[`CTL_MASTER_EN];
   wire       four_wire = (sel_mode != `SEL_MODE_3WIRE);
   // 3-wire slave is always selected; 4-wire uses the nss input
   wire       selected  = ~four_wire | ~nss_s_q[1];
   wire       sck_rise  = sck_s_q[1] & ~sck_s_q[2];
   wire       sck_fall  = ~sck_s_q[1] & sck_s_q[2];
   wire       nss_fall  = ~nss_s_q[1] & nss_s_q[2];
   wire       mode_fault = master & (sel_mode == `SEL_MODE_4SLAVE) & nss_fall;
   wire       tick_done = (tick_q == `DIV_ZERO);
   wire       m_idle    = mstate_q[0];
   wire       busy      = ~m_idle | slave_busy_q;

   // slave shifting only while selected, so a high nss masks sck
   wire       s_active  = slave & selected;
   wire       s_rise    = s_active & sck_rise;
   wire       s_fall    = s_active & sck_fall;

   // a byte completes on the eighth trailing edge in either role
   wire       m_last    = mstate_q[2] & tick_done & (bit_q == `BIT_LAST);
   wire       s_last    = s_fall & (bit_q == `BIT_LAST);
   wire       xfer_done = (m_last | s_last) & ~mode_fault;

   // buffer moves into the shifter only when the shifter is free
   wire       m_start   = master & m_idle & tx_full_q & ~mode_fault;
   wire       s_load    = slave & ~slave_busy_q & tx_full_q & ~s_rise;

   // register strobes
   wire       wr_ctl    = wr_i & hit(addr_i, `ADDR_CONTROL);
   wire       wr_st     = wr_i & hit(addr_i, `ADDR_STATUS);
   wire       wr_dat    = wr_i & hit(addr_i, `ADDR_DATA);
   wire       wr_div    = wr_i & hit(addr_i, `ADDR_DIVIDER);
   wire       rd_dat    = rd_i & hit(addr_i, `ADDR_DATA);

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   // every pin passes two flops before anything looks at it
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         sck_s_q  <= 3'b000;
         nss_s_q  <= 3'b111;
         mosi_s_q <= 2'b00;
         miso_s_q <= 2'b00;
      end else begin
         sck_s_q  <= {sck_s_q[1:0], sck_i};
         nss_s_q  <= {nss_s_q[1:0], nss_i};
         mosi_s_q <= {mosi_s_q[0], mosi_i};
         miso_s_q <= {miso_s_q[0], miso_i};
      end
   end

   // ----------------------------------------------------------------------
   // control and divider registers
   // ----------------------------------------------------------------------
   // a mode fault overrides a same-cycle software write of the enables
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctl_q <= `CTL_RESET;
         div_q <= `DIV_RESET;
      end else begin
         if (wr_ctl) begin
            ctl_q <= wdata_i[3:0];
         end
         if (mode_fault) begin
            ctl_q[`CTL_MASTER_EN] <= 1'b0;
            ctl_q[`CTL_PORT_EN]   <= 1'b0;
         end
         if (wr_div) begin
            div_q <= wdata_i;
         end
      end
   end

   // ----------------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------------
   // write one to clear; a flag raised in the same cycle stays set
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         flag_q <= `FLAG_RESET;
      end else begin
         flag_q <= (flag_q & ~({`FLAG_W{wr_st}} & wdata_i[`FLAG_W-1:0]))
                   | {xfer_done & slave & rx_full_q & ~rd_dat,
                      mode_fault,
                      wr_dat & tx_full_q,
                      xfer_done};
      end
   end

   // ----------------------------------------------------------------------
   // transmit and receive buffers
   // ----------------------------------------------------------------------
   // accepted writes land in the buffer, never in the live shifter; a write to a full buffer is dropped
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         tx_buf_q  <= `BYTE_ZERO;
         tx_full_q <= 1'b0;
         rx_buf_q  <= `BYTE_ZERO;
         rx_full_q <= 1'b0;
      end else begin
         if (wr_dat & ~tx_full_q) begin
            tx_buf_q  <= wdata_i;
            tx_full_q <= 1'b1;
         end else if (m_start | s_load) begin
            tx_full_q <= 1'b0;
         end
         // a slave keeps an unread byte; a read in the same cycle frees it
         if (xfer_done & ~(slave & rx_full_q & ~rd_dat)) begin
            rx_buf_q  <= {shift_q[`DATA_W-2:0], sample_q};
            rx_full_q <= 1'b1;
         end else if (rd_dat) begin
            rx_full_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // master sequencer
   // ----------------------------------------------------------------------
   // each half period lasts div_q + 1 clocks; sck idles low, data is
   // sampled on the rising edge and shifted on the falling edge
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         mstate_q  <= M_IDLE;
         tick_q    <= `DIV_ZERO;
         sck_int_q <= 1'b0;
      end else if (~master | mode_fault) begin
         mstate_q  <= M_IDLE;
         tick_q    <= `DIV_ZERO;
         sck_int_q <= 1'b0;
      end else begin
         case (mstate_q)
            M_IDLE: begin
               if (m_start) begin
                  mstate_q <= M_LOW;
                  tick_q   <= div_q;
               end
            end
            M_LOW: begin
               if (tick_done) begin
                  mstate_q  <= M_HIGH;
                  sck_int_q <= 1'b1;
                  tick_q    <= div_q;
               end else begin
                  tick_q <= tick_q - 8'h01;
               end
            end
            M_HIGH: begin
               if (tick_done) begin
                  sck_int_q <= 1'b0;
                  tick_q    <= div_q;
                  mstate_q  <= (bit_q == `BIT_LAST) ? M_IDLE : M_LOW;
               end else begin
                  tick_q <= tick_q - 8'h01;
               end
            end
            default: begin
               mstate_q  <= M_IDLE;
               tick_q    <= `DIV_ZERO;
               sck_int_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // shift register and bit counter, shared by both roles
   // ----------------------------------------------------------------------
   // msb leaves first; the incoming bit enters at the lsb on the shift
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         shift_q      <= `BYTE_ZERO;
         sample_q     <= 1'b0;
         bit_q        <= `BIT_ZERO;
         slave_busy_q <= 1'b0;
      end else if (m_start | s_load) begin
         shift_q      <= tx_buf_q;
         bit_q        <= `BIT_ZERO;
      end else if (master) begin
         if (mstate_q[1] & tick_done) begin
            sample_q <= miso_s_q[1];
         end
         if (mstate_q[2] & tick_done) begin
            shift_q <= {shift_q[`DATA_W-2:0], sample_q};
            bit_q   <= bit_q + `BIT_ONE;
         end
      end else if (~s_active) begin
         // deselection drops a partial byte so the next frame starts clean
         bit_q        <= `BIT_ZERO;
         slave_busy_q <= 1'b0;
      end else begin
         if (s_rise) begin
            sample_q     <= mosi_s_q[1];
            slave_busy_q <= 1'b1;
         end
         if (s_fall) begin
            shift_q <= {shift_q[`DATA_W-2:0], sample_q};
            bit_q   <= bit_q + `BIT_ONE;
            if (bit_q == `BIT_LAST) begin
               slave_busy_q <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------------
   // all pin outputs come from flops; one clock of lag is far below the
   // slowest half period and keeps glitches off the pads
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         sck_o        <= 1'b0;
         sck_oe_o     <= 1'b0;
         mosi_o       <= 1'b0;
         mosi_oe_o    <= 1'b0;
         miso_o       <= 1'b0;
         miso_oe_o    <= 1'b0;
         nss_o        <= 1'b1;
         nss_oe_o     <= 1'b0;
         nss_pin_en_o <= 1'b0;
      end else begin
         sck_o        <= sck_int_q;
         sck_oe_o     <= master;
         mosi_o       <= shift_q[`DATA_W-1];
         mosi_oe_o    <= master;
         miso_o       <= shift_q[`DATA_W-1];
         miso_oe_o    <= slave & selected;
         nss_o        <= ctl_q[`CTL_SEL_LEVEL];
         nss_oe_o     <= port_en & ctl_q[`CTL_SEL_OUT_EN];
         nss_pin_en_o <= four_wire;
      end
   end

   // ----------------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------------
   // data appear the cycle after the read strobe and only then
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= `BYTE_ZERO;
      end else if (rd_i) begin
         if (hit(addr_i, `ADDR_CONTROL)) begin
            rdata_o <= {4'h0, ctl_q};
         end else if (hit(addr_i, `ADDR_STATUS)) begin
            rdata_o <= {1'b0, busy, rx_full_q, tx_full_q, flag_q};
         end else if (rd_dat) begin
            rdata_o <= rx_buf_q;
         end else if (hit(addr_i, `ADDR_DIVIDER)) begin
            rdata_o <= div_q;
         end else begin
            rdata_o <= `BYTE_ZERO;
         end
      end else begin
         rdata_o <= `BYTE_ZERO;
      end
   end

endmodule // spi_serial_port

// ==== dv/spi_far_end.sv ====
// far side of the spi link: a slave while the port is master, a master otherwise.
// assumes the bench resolves every line from the enables and gates sck.
`timescale 1ns/100ps
module spi_far_end (
   input  wire sck_i,
   input  wire mosi_i,
   input  wire miso_i,
   output reg  miso_o = 1'b1,
   output reg  sck_o  = 1'b0,
   output reg  mosi_o = 1'b0,
   output reg  nss_o  = 1'b1
);
   reg [7:0] reply_q = 8'hA5;
   reg [7:0] take_q  = 8'h00;
   reg [2:0] cnt_q   = 3'h0;
   reg [7:0] got_q [$];

   // slave role: sample on the rise, keep whole bytes only
   always @(posedge sck_i) begin
      take_q = {take_q[6:0], mosi_i};
      cnt_q = cnt_q + 3'h1;
      if (cnt_q == 3'h0)
         got_q.push_back(take_q);
   end

   // shift on the fall, msb first; reload the reply at each byte end
   always @(negedge sck_i) begin
      reply_q = (cnt_q == 3'h0) ? 8'hA5 : {reply_q[6:0], ~reply_q[7]};
      miso_o = reply_q[7];
   end

   // master role: 320 ns sck only inside frames, data set up a half before
   task frame(input reg sel, input reg [7:0] b, output reg [7:0] r);
      integer i;
      begin
         r = 8'h00;
         nss_o = !sel;
         for (i = 7; i >= 0; i = i - 1) begin
            mosi_o = b[i];
            #160 sck_o = 1'b1;
            r = {r[6:0], miso_i};
            #160 sck_o = 1'b0;
         end
         // hold select past the slave's completion, then toggle the data line
         #320 nss_o = 1'b1;
         mosi_o = ~mosi_o;
      end
   endtask

   task select(input reg v);
      nss_o = v;
   endtask
endmodule // spi_far_end

// ==== dv/spi_serial_port_props.sv ====
// checker for the spi serial port: relations between its pins and read port.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module spi_serial_port_props (
   input wire       clock_i,
   input wire       rst_n_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   input wire       sck_o,
   input wire       sck_oe_o,
   input wire       mosi_o,
   input wire       mosi_oe_o,
   input wire       miso_oe_o,
   input wire       nss_i,
   input wire       nss_oe_o,
   input wire       nss_pin_en_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // ------------------------------------------------------------------
   // steps of select handling
   // ------------------------------------------------------------------
   // five samples leave room for the two-flop synchroniser and the output flop
   sequence unselected_s;
      (nss_i && nss_pin_en_o && !nss_oe_o) [*5];
   endsequence
   sequence nss_pulled_s;
      (sck_oe_o && nss_pin_en_o && !nss_oe_o && nss_i) ##1 !nss_i [*4];
   endsequence

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   role_pair_a: assert property (mosi_oe_o == sck_oe_o)
      else $error("mosi enable differs from sck enable");
   miso_dir_a: assert property (miso_oe_o |-> !mosi_oe_o)
      else $error("miso driven while master");
   deselect_a: assert property (unselected_s |-> !miso_oe_o)
      else $error("miso driven while not selected");
   mosi_hold_a: assert property ((sck_oe_o && $changed(mosi_o)) |-> !sck_o)
      else $error("mosi moved while sck high");
   sck_owner_a: assert property (sck_o |-> sck_oe_o)
      else $error("sck driven high while not master");
   nss_route_a: assert property (nss_oe_o |-> nss_pin_en_o)
      else $error("select driven but not routed");
   fault_drop_a: assert property (nss_pulled_s |-> ##[0:4] !sck_oe_o)
      else $error("master kept bus after select pulled low");
   read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its cycle");
endmodule // spi_serial_port_props

// ==== dv/test_spi_serial_port.sv ====
// testbench for the spi serial port: register tasks plus a far-end model.
// assumes the constants header and the far-end and checker modules.
`timescale 1ns/100ps
`include "spi_serial_port_consts.vh"
module test_spi_serial_port;
   reg                clock_i = 1'b0;
   reg                rst_n_i = 1'b0;
   reg  [`ADDR_W-1:0] addr_i  = 4'h0;
   reg  [`DATA_W-1:0] wdata_i = 8'h00;
   reg                wr_i    = 1'b0;
   reg                rd_i    = 1'b0;
   wire [`DATA_W-1:0] rdata_o;
   wire               sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   wire               nss_o, nss_oe_o, nss_pin_en_o;
   wire               miso_far, sck_far, mosi_far, nss_far;
   integer            mismatches = 0;
   integer            n_tests = 0;
   reg  [7:0]         v;
   reg  [7:0]         r;

   // ------------------------------------------------------------------
   // wires resolved from the port's enables
   // ------------------------------------------------------------------
   wire sck_w  = sck_oe_o ? sck_o : sck_far;
   wire mosi_w = mosi_oe_o ? mosi_o : mosi_far;
   wire miso_w = miso_oe_o ? miso_o : miso_far;
   wire nss_w  = nss_oe_o ? nss_o : nss_far;

   spi_serial_port spi_serial_port_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w),
      .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oe_o(miso_oe_o), .nss_i(nss_w), .nss_o(nss_o), .nss_oe_o(nss_oe_o),
      .nss_pin_en_o(nss_pin_en_o));
   spi_far_end spi_far_end_i (.sck_i(sck_oe_o & sck_o), .mosi_i(mosi_w),
      .miso_i(miso_w), .miso_o(miso_far), .sck_o(sck_far), .mosi_o(mosi_far),
      .nss_o(nss_far));

   // 25 mhz system clock
   initial begin
      forever #20 clock_i = ~clock_i;
   end

   // ------------------------------------------------------------------
   // register port tasks and checks
   // ------------------------------------------------------------------
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clock_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clock_i);
         wr_i <= 1'b0;
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input [3:0] a, output [7:0] d);
      begin
         @(posedge clock_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clock_i);
         rd_i <= 1'b0;
         #1 d = rdata_o;
      end
   endtask
   task chk(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task rchk(input [3:0] a, input [7:0] m, input [7:0] e, input [8*12-1:0] name);
      begin
         rd(a, v);
         chk(name, e, v & m);
      end
   endtask
   // pins follow a register change one cycle later
   task settle;
      begin
         repeat (2) @(posedge clock_i);
         #1;
      end
   endtask
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // bounded status wait; running out ends the run as a failure
   task poll(input [7:0] mask, input [7:0] want);
      integer n;
      begin
         v = ~want;
         for (n = 0; n < 600 && (v & mask) !== want; n = n + 1)
            rd(`ADDR_STATUS, v);
         if ((v & mask) !== want) begin
            mismatches = mismatches + 1;
            $display("ERROR status wait expected %h seen %h", want, v & mask);
            test_done;
         end
      end
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rchk(`ADDR_CONTROL, 8'hFF, `BYTE_ZERO, "control");
      rchk(`ADDR_STATUS, 8'hFF, `BYTE_ZERO, "status");
      rchk(`ADDR_DIVIDER, 8'hFF, `DIV_RESET, "divider");
      wr(4'h2, 8'hFF);
      rchk(4'h2, 8'hFF, `BYTE_ZERO, "unmapped");
      chk("nss reset", 8'h00, {6'h0, nss_oe_o, nss_o});
      // master, 3-wire: two bytes back to back, a third write collides
      wr(`ADDR_DIVIDER, 8'h06);
      rchk(`ADDR_DIVIDER, 8'hFF, 8'h06, "divider");
      wr(`ADDR_CONTROL, 8'h03);
      settle;
      chk("master pins", 8'h03, {6'h0, mosi_oe_o, sck_oe_o});
      wr(`ADDR_DATA, 8'h3C);
      wr(`ADDR_DATA, 8'h5A);
      wr(`ADDR_DATA, 8'h77);
      poll(8'h51, 8'h01);
      chk("sent first", 8'h3C, spi_far_end_i.got_q[0]);
      chk("sent second", 8'h5A, spi_far_end_i.got_q[1]);
      chk("sent count", 8'h02, 8'(spi_far_end_i.got_q.size()));
      rchk(`ADDR_STATUS, 8'hFF, 8'h23, "master flags");
      rchk(`ADDR_DATA, 8'hFF, 8'hA5, "master rx");
      wr(`ADDR_STATUS, 8'h0F);
      rchk(`ADDR_STATUS, 8'hFF, `BYTE_ZERO, "cleared");
      // select driven out at the select level bit
      wr(`ADDR_CONTROL, 8'h0B);
      settle;
      chk("nss drive", 8'h03, {6'h0, nss_oe_o, nss_pin_en_o});
      chk("nss low", 8'h00, {7'h0, nss_o});
      wr(`ADDR_CONTROL, 8'h0F);
      settle;
      chk("nss high", 8'h01, {7'h0, nss_o});
      // multi-master: select pulled low takes the master away
      wr(`ADDR_CONTROL, 8'h07);
      settle;
      spi_far_end_i.select(1'b0);
      repeat (10) @(posedge clock_i);
      rchk(`ADDR_CONTROL, 8'hFF, 8'h04, "fault ctl");
      rchk(`ADDR_STATUS, 8'hFF, 8'h04, "fault flag");
      chk("fault sck", 8'h00, {7'h0, sck_oe_o});
      spi_far_end_i.select(1'b1);
      wr(`ADDR_STATUS, 8'h0F);
      // 4-wire slave: unselected frame ignored, then a byte, then overrun
      wr(`ADDR_CONTROL, 8'h05);
      wr(`ADDR_DATA, 8'hC3);
      settle;
      chk("slave pins", 8'h00, {5'h0, mosi_oe_o, sck_oe_o, miso_oe_o});
      spi_far_end_i.frame(1'b0, 8'hFF, r);
      rchk(`ADDR_STATUS, 8'h0F, 8'h00, "ignored");
      spi_far_end_i.frame(1'b1, 8'h96, r);
      chk("slave sent", 8'hC3, r);
      poll(8'h01, 8'h01);
      spi_far_end_i.frame(1'b1, 8'h0F, r);
      repeat (8) @(posedge clock_i);
      rchk(`ADDR_STATUS, 8'h0F, 8'h09, "overrun");
      rchk(`ADDR_DATA, 8'hFF, 8'h96, "kept byte");
      // 3-wire slave: always selected, select not routed
      wr(`ADDR_STATUS, 8'h0F);
      wr(`ADDR_CONTROL, 8'h01);
      wr(`ADDR_DATA, 8'h69);
      settle;
      chk("3-wire pins", 8'h01, {6'h0, nss_pin_en_o, miso_oe_o});
      spi_far_end_i.frame(1'b0, 8'h5A, r);
      chk("3-wire tx", 8'h69, r);
      poll(8'h01, 8'h01);
      rchk(`ADDR_DATA, 8'hFF, 8'h5A, "3-wire rx");
      // disabled port releases miso
      wr(`ADDR_CONTROL, 8'h00);
      settle;
      chk("disabled", 8'h00, {6'h0, miso_oe_o, nss_pin_en_o});
      test_done;
   end
endmodule // test_spi_serial_port

bind spi_serial_port spi_serial_port_props spi_serial_port_props_i (.clock_i(clock_i),
   .rst_n_i(rst_n_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_o(sck_o),
   .sck_oe_o(sck_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
   .miso_oe_o(miso_oe_o), .nss_i(nss_i), .nss_oe_o(nss_oe_o),
   .nss_pin_en_o(nss_pin_en_o));

// ==== pkg/spi_serial_port_consts.vh ====
// constants for the spi serial port: register offsets, field positions,
// reset values and widths.
// assumes it is included by bare name into the design file.
`ifndef SPI_SERIAL_PORT_CONSTS_VH
`define SPI_SERIAL_PORT_CONSTS_VH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_W            4
`define ADDR_CONTROL      4'h0
`define ADDR_STATUS       4'h4
`define ADDR_DATA         4'h8
`define ADDR_DIVIDER      4'hC

// ----------------------------------------------------------------------
// serial_control_register fields
// ----------------------------------------------------------------------
`define CTL_PORT_EN       0
`define CTL_MASTER_EN     1
`define CTL_SEL_LEVEL     2
`define CTL_SEL_OUT_EN    3
`define SEL_MODE_3WIRE    2'b00
`define SEL_MODE_4SLAVE   2'b01

// ----------------------------------------------------------------------
// status register fields (bits 3:0 write one to clear, 6:4 read only)
// ----------------------------------------------------------------------
`define ST_DONE           0
`define ST_WRITE_COLLISION_FLAG           1
`define ST_MODE_FAULT_FLAG           2
`define ST_OVRN           3
`define ST_TX_FULL        4
`define ST_RX_FULL        5
`define ST_BUSY           6
`define FLAG_W            4

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define DATA_W            8
`define BIT_CNT_W         3
`define BIT_LAST          3'h7
`define BIT_ZERO          3'h0
`define BIT_ONE           3'h1
`define CTL_RESET         4'h0
`define FLAG_RESET        4'h0
`define BYTE_ZERO         8'h00
`define DIV_RESET         8'h04
`define DIV_ZERO          8'h00

`endif
